// [src/shg_map.svh]
// Constants for the statistics host bus glue.
// Assumes one 50 MHz ref_clk and a synchronous active-low reset.
// Operation
// - Chip select never precedes valid read/write
// - Host strobes follow its chip select
// - Two tri-state halves form data transceiver
// - Frame valid qualified by transmit ready
// - Host holds writes four wait states
// - Host holds reads five wait states
// - Wait count ends cycles, ready unused
// - One command collects counters, then interrupt
// - Up to sixteen repeater controllers supported
// - System clock is reference divided by two
// - Write select inside the write pulse
// - Qualified valid only with valid and ready
// - Direction signal steers register data buffer
`ifndef SHG_MAP_SVH
`define SHG_MAP_SVH
`define SHG_WRITE_WAITS 4'h4
`define SHG_READ_WAITS 4'h5
`define SHG_WR_SELECT_SPAN (`SHG_WRITE_WAITS - 4'h2)
`define SHG_RD_SELECT_SPAN (`SHG_READ_WAITS - 4'h2)
`define SHG_MAX_CTRL 5'h10
`define SHG_CTRL_IDX_W 4
`define SHG_COUNTERS_PER_CTRL 8'h0C
`define SHG_REF_MHZ 50
`define SHG_SYS_MHZ 25
`define SHG_CLK_DIV (`SHG_REF_MHZ / `SHG_SYS_MHZ)
`endif

// [src/shg_pkg.sv]
// Types shared by both ends of the statistics host bus glue.
// Assumes shg_map.svh is on the include path.
package shg_pkg;
  typedef enum {SHG_IDLE, SHG_ACCESS, SHG_HOLD, SHG_END} shg_host_state_t;
  typedef enum {SHG_COLLECT_IDLE, SHG_COLLECT_RUN, SHG_COLLECT_DONE} shg_collect_state_t;
endpackage

// [src/shg_bus_if.sv]
// Interface joining the host bus end and the glue end.
// Assumes a single clock shared by both ends.
interface shg_bus_if;
  logic select_n;
  logic write_n;
  logic read_n;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic stats_irq;
  modport host (output select_n, output write_n, output read_n, output wdata, input rdata, input stats_irq);
  modport glue (input select_n, input write_n, input read_n, input wdata, output rdata, output stats_irq);
endinterface

// [src/shg_glue.sv]
// Glue end: conditions select and read/write for the statistics chip,
// builds the register data transceiver and qualifies the frame valid.
// Assumes host strobes are synchronous to ref_clk.
`include "shg_map.svh"

module shg_glue
  import shg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  shg_bus_if.glue bus,
  input wire logic reg_dir,
  input wire logic rdio_in,
  output logic rdio_out,
  output logic rdio_oe,
  output logic rdio_to_chip,
  output logic rdio_to_chip_oe,
  input wire logic mgmt_frame_valid_n,
  input wire logic tx_ready,
  output logic qualified_frame_valid_n,
  output logic gated_read_write,
  output logic gated_stats_select_n,
  input wire logic cycle_ready_n,
  input wire logic [7:0] chip_rdata,
  output logic [7:0] chip_wdata,
  input wire logic collect_cmd,
  input wire logic [`SHG_CTRL_IDX_W-1:0] ctrl_count_m1,
  output logic [`SHG_CTRL_IDX_W-1:0] ctrl_index,
  output logic collect_busy,
  output logic sys_clk_out
);

  // ************************
  // Strobe sampling
  // ************************
  logic sel_q;
  logic wr_q;
  logic rd_q;
  logic [7:0] rdata_q;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      sel_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      sel_q <= ~bus.select_n;
      wr_q <= ~bus.write_n;
      rd_q <= ~bus.read_n;
    end
  end

  // ************************
  // Strobe length tracking
  // ************************
  // The host strobes reach us a cycle late, so we cannot follow their
  // rising edge. Counting how long a strobe has stood lets select be
  // freed ahead of the host's programmed end of cycle.
  logic [3:0] strobe_len;
  logic wr_open;
  logic rd_open;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      strobe_len <= 4'h0;
    else if (!(sel_q && (wr_q || rd_q)))
      strobe_len <= 4'h0;
    else if (strobe_len != 4'hF)
      strobe_len <= strobe_len + 4'h1;
  end
  // Select may stand only while the strobe is well inside its count
  assign wr_open = (strobe_len < `SHG_WR_SELECT_SPAN);
  assign rd_open = (strobe_len < `SHG_RD_SELECT_SPAN);

  // ************************
  // Read/write and select conditioning
  // ************************
  // Read/write defaults high; it drops only once a write is seen, and
  // select follows one edge later so it never leads the direction line.
  // Select is freed by the strobe-length count, ahead of the host's end.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      gated_read_write <= 1'b1;
    else if (sel_q && wr_q)
      gated_read_write <= 1'b0;
    else if (!(sel_q && wr_q) && gated_stats_select_n)
      gated_read_write <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      gated_stats_select_n <= 1'b1;
    else if (sel_q && rd_q && gated_read_write && rd_open)
      gated_stats_select_n <= 1'b0;
    else if (sel_q && wr_q && !gated_read_write && !bus.write_n && wr_open)
      gated_stats_select_n <= 1'b0;
    else
      gated_stats_select_n <= 1'b1;
  end
  // Cycles end on the host wait count; the chip's ready is not looked at.
  logic unused_ready;
  assign unused_ready = cycle_ready_n;

  // ************************
  // Chip data path
  // ************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      chip_wdata <= 8'h00;
      rdata_q <= 8'h00;
    end
    else
    begin
      chip_wdata <= bus.wdata;
      // Read data is caught while the chip is selected for a read and held
      // after, because the chip lets go of its data once select rises.
      if (!gated_stats_select_n && gated_read_write)
        rdata_q <= chip_rdata;
    end
  end
  assign bus.rdata = rdata_q;

  // ************************
  // Register data transceiver
  // ************************
  // Direction high: chip drives out; low: we drive toward the chip.
  // One unregistered input pin feeds both halves; only the enables tell them apart.
  assign rdio_out = rdio_in;
  assign rdio_oe = rst_b & reg_dir;
  assign rdio_to_chip = rdio_in;
  assign rdio_to_chip_oe = rst_b & ~reg_dir;

  // ************************
  // Frame valid qualification
  // ************************
  // Framing noise outside transmit periods would otherwise be counted.
  assign qualified_frame_valid_n = mgmt_frame_valid_n | ~tx_ready;

  // ************************
  // Counter collection
  // ************************
  // Counter reads are paced one per clock; the interrupt stays up until
  // the next command so a slow processor cannot miss it.
  shg_collect_state_t state;
  logic [7:0] counter_idx;
  logic irq_q;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state <= SHG_COLLECT_IDLE;
      ctrl_index <= '0;
      counter_idx <= 8'h00;
      irq_q <= 1'b0;
    end
    else
    begin
      unique case (state)
        SHG_COLLECT_IDLE:
        begin
          if (collect_cmd)
          begin
            state <= SHG_COLLECT_RUN;
            ctrl_index <= '0;
            counter_idx <= 8'h00;
            irq_q <= 1'b0;
          end
        end
        SHG_COLLECT_RUN:
        begin
          if (counter_idx == `SHG_COUNTERS_PER_CTRL - 8'h01)
          begin
            counter_idx <= 8'h00;
            if (ctrl_index == ctrl_count_m1)
              state <= SHG_COLLECT_DONE;
            else
              ctrl_index <= ctrl_index + 1'b1;
          end
          else
            counter_idx <= counter_idx + 8'h01;
        end
        SHG_COLLECT_DONE:
        begin
          irq_q <= 1'b1;
          state <= SHG_COLLECT_IDLE;
        end
      endcase
    end
  end
  assign collect_busy = (state != SHG_COLLECT_IDLE);
  assign bus.stats_irq = irq_q;

  // ************************
  // System clock divider
  // ************************
  // Stands in for the 25 MHz system clock; toggling gives half the 50 MHz reference rate.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      sys_clk_out <= 1'b0;
    else
      sys_clk_out <= ~sys_clk_out;
  end

endmodule // shg_glue

// [src/shg_host.sv]
// Host end: runs an I/O cycle with select first, then strobe, held for
// the programmed wait count. Assumes one clock for both ends.
`include "shg_map.svh"

module shg_host
  import shg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  shg_bus_if.host bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic resp_valid,
  output logic [7:0] resp_rdata,
  output logic irq
);

  shg_host_state_t state;
  logic [3:0] waits;
  logic is_write;
  logic [7:0] wdata_q;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state <= SHG_IDLE;
      waits <= 4'h0;
      is_write <= 1'b0;
      wdata_q <= 8'h00;
      bus.select_n <= 1'b1;
      bus.write_n <= 1'b1;
      bus.read_n <= 1'b1;
      resp_valid <= 1'b0;
      resp_rdata <= 8'h00;
    end
    else
    begin
      resp_valid <= 1'b0;
      unique case (state)
        SHG_IDLE:
        begin
          if (req_valid)
          begin
            bus.select_n <= 1'b0;
            is_write <= req_write;
            wdata_q <= req_wdata;
            state <= SHG_ACCESS;
          end
        end
        SHG_ACCESS:
        begin
          bus.write_n <= ~is_write;
          bus.read_n <= is_write;
          waits <= is_write ? `SHG_WRITE_WAITS : `SHG_READ_WAITS;
          state <= SHG_HOLD;
        end
        SHG_HOLD:
        begin
          if (waits == 4'h0)
          begin
            bus.write_n <= 1'b1;
            bus.read_n <= 1'b1;
            resp_rdata <= bus.rdata;
            resp_valid <= ~is_write;
            state <= SHG_END;
          end
          else
            waits <= waits - 4'h1;
        end
        SHG_END:
        begin
          bus.select_n <= 1'b1;
          state <= SHG_IDLE;
        end
      endcase
    end
  end
  assign bus.wdata = wdata_q;
  assign req_ready = (state == SHG_IDLE);
  assign irq = bus.stats_irq;

endmodule // shg_host

// [sim/shg_checker.sv]
// Checker for the host bus between the host end and the glue end.
// Assumes one clock; instantiated beside the interface.
module shg_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic select_n,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic [7:0] wdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_sel_first; $fell(select_n) |=> $fell(write_n) || $fell(read_n); endproperty
  a_sel_first: assert property (p_sel_first) else $error("strobe late after select");
  property p_strobe_sel; !write_n || !read_n |-> !select_n; endproperty
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without select");
  property p_one_strobe; write_n || read_n; endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
  property p_wr_hold; $fell(write_n) |-> !write_n [*5] ##1 write_n; endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write strobe length wrong");
  property p_rd_hold; $fell(read_n) |-> !read_n [*6] ##1 read_n; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read strobe length wrong");
  property p_end; $rose(write_n) || $rose(read_n) |-> !select_n ##1 select_n; endproperty
  a_end: assert property (p_end) else $error("select not released after strobe");
  property p_wdata; !write_n && !$past(write_n) |-> $stable(wdata); endproperty
  a_wdata: assert property (p_wdata) else $error("write data moved in strobe");
  property p_idle; $rose(select_n) |-> write_n && read_n; endproperty
  a_idle: assert property (p_idle) else $error("select released under strobe");
endmodule // shg_checker

// [sim/stats_host_bus_glue_test.sv]
// Bench joining host end and glue end through the bus interface.
// Assumes the src files and shg_map.svh are compiled first.
`include "shg_map.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module stats_host_bus_glue_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst_b = 0, req_valid = 0, req_write = 0, reg_dir = 1, collect_cmd = 0;
  logic mgmt_frame_valid_n = 1, tx_ready = 0, w, s, rdio_in = 0, cycle_ready_n = 1;
  logic [7:0] req_wdata = 8'h00, chip_rdata = 8'h00, resp_rdata, chip_wdata, d;
  logic [3:0] ctrl_count_m1 = 4'h0, ctrl_index;
  logic req_ready, resp_valid, irq, rdio_out, rdio_oe, rdio_to_chip, rdio_to_chip_oe;
  logic qualified_frame_valid_n, gated_read_write, gated_stats_select_n, collect_busy, sys_clk_out;
  int mismatches = 0, checks = 0;
  shg_bus_if bus ();
  shg_host shg_host_i (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus.host), .req_valid(req_valid),
    .req_write(req_write), .req_wdata(req_wdata), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .irq(irq));
  shg_glue shg_glue_i (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus.glue), .reg_dir(reg_dir),
    .rdio_in(rdio_in), .rdio_out(rdio_out), .rdio_oe(rdio_oe), .rdio_to_chip(rdio_to_chip),
    .rdio_to_chip_oe(rdio_to_chip_oe), .mgmt_frame_valid_n(mgmt_frame_valid_n), .tx_ready(tx_ready),
    .qualified_frame_valid_n(qualified_frame_valid_n), .gated_read_write(gated_read_write),
    .gated_stats_select_n(gated_stats_select_n), .cycle_ready_n(cycle_ready_n), .chip_rdata(chip_rdata),
    .chip_wdata(chip_wdata), .collect_cmd(collect_cmd), .ctrl_count_m1(ctrl_count_m1),
    .ctrl_index(ctrl_index), .collect_busy(collect_busy), .sys_clk_out(sys_clk_out));
  shg_checker shg_checker_i (.ref_clk(ref_clk), .rst_b(rst_b), .select_n(bus.select_n),
    .write_n(bus.write_n), .read_n(bus.read_n), .wdata(bus.wdata));
  always #5 ref_clk = ~ref_clk;
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Framing valid reaches the chip only when asserted with transmit ready
  function automatic logic exp_qual(input logic valid_n, input logic ready);
    return (valid_n == 1'b0 && ready == 1'b1) ? 1'b0 : 1'b1;
  endfunction
  // Fixed 16-cycle window covers the longest read walk with margin
  task automatic xfer(input logic wr, input logic [7:0] v);
    logic [7:0] got;
    logic seen;
    logic hit;
    got = 8'h00;
    seen = 1'b0;
    hit = 1'b0;
    req_write = wr;
    req_wdata = v;
    chip_rdata = v;
    req_valid = 1'b1;
    @(posedge ref_clk);
    #1 req_valid = 1'b0;
    repeat (16)
    begin
      @(posedge ref_clk);
      #1;
      if (gated_stats_select_n === 1'b0)
      begin
        hit = 1'b1;
        `CHK("rw", ~wr, gated_read_write)
        if (wr) `CHK("strobe", 1'b0, bus.write_n)
        if (wr) `CHK("wdata", v, chip_wdata)
      end
      if (resp_valid === 1'b1)
      begin
        got = resp_rdata;
        seen = 1'b1;
      end
    end
    `CHK("select", 1'b1, hit)
    `CHK("resp", ~wr, seen)
    if (!wr) `CHK("rdata", v, got)
  endtask
  task automatic collect(input logic [3:0] n);
    int c;
    c = 0;
    ctrl_count_m1 = n;
    collect_cmd = 1'b1;
    @(posedge ref_clk);
    #1 collect_cmd = 1'b0;
    `CHK("irq_clr", 1'b0, irq)
    while (collect_busy === 1'b1 && c < 400)
    begin
      @(posedge ref_clk);
      #1 c++;
    end
    // The done state still reads busy, so one edge more than the reads
    `CHK("span", `SHG_COUNTERS_PER_CTRL * (n + 1) + 1, c)
    `CHK("ctrl", n, ctrl_index)
    `CHK("irq", 1'b1, irq)
    $display("collect %0d done", n);
  endtask
  initial
  begin
    void'($urandom(32'hFA642DA6));
    repeat (20) @(posedge ref_clk);
    #1 `CHK("rst_oe", 1'b0, rdio_oe)
    `CHK("rst_sel", 1'b1, gated_stats_select_n)
    rst_b = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      {rdio_in, reg_dir, mgmt_frame_valid_n, tx_ready} = i[3:0];
      @(posedge ref_clk);
      #1 `CHK("qual", exp_qual(mgmt_frame_valid_n, tx_ready), qualified_frame_valid_n)
      `CHK("oe", reg_dir, rdio_oe)
      `CHK("oe_n", ~reg_dir, rdio_to_chip_oe)
      `CHK("out", rdio_in, rdio_out)
      `CHK("to_chip", rdio_in, rdio_to_chip)
    end
    s = sys_clk_out;
    @(posedge ref_clk);
    #1 `CHK("div", ~s, sys_clk_out)
    $display("pins done");
    xfer(1'b1, 8'hFF);
    xfer(1'b0, 8'h00);
    for (int i = 0; i < 30; i++)
    begin
      w = 1'($urandom);
      cycle_ready_n = 1'($urandom);
      d = 8'($urandom);
      xfer(w, d);
    end
    $display("bus done");
    collect(4'hF);
    collect(4'h0);
    collect(4'($urandom));
    conclude;
  end
  initial
  begin
    #50000;
    mismatches++;
    conclude;
  end
endmodule // stats_host_bus_glue_test
